// File: core/rpos_pkg.sv
// Function
// RULE1 - Accept undervoltage, watchdog, pin and software resets; first three run power-on.
// RULE2 - After any reset registers take initial values and fetch starts at 0x0000.
// RULE3 - Power-on sequence: power stabilization stage, then clock stabilization stage.
// RULE4 - Power stabilization lasts about 4.6 ms before clock setup.
// RULE5 - End of power stabilization loads the clock source option and starts it.
// RULE6 - Clock stabilization counts 2048 selected clocks and 5 low-speed clocks.
// RULE7 - Supply at or below 1.8 V asserts system reset.
// RULE8 - Watchdog resets only when firmware fails to clear it before expiry.
// RULE9 - Writing key 0x5A to the watchdog clear register restarts the count.
// RULE10 - Always-on watchdog keeps counting in every CPU state.
// RULE11 - Enabled watchdog counts in normal mode and halts in idle or stop.
// RULE12 - Disabled watchdog never counts and never resets.
// RULE13 - Watchdog clock is low-speed oscillator divided by 4, 8, 16 or 32.
// RULE14 - Reset pin option: debounced reset, plain reset, or general-purpose pin.
// RULE15 - Clock source option picks one of five sources; unused oscillator pins become GPIO.
// RULE16 - Watchdog expires after 256 prescaled ticks.
// RULE17 - Debounced pin resets only after 8 ms continuous low; shorter pulses ignored.
// RULE18 - Software reset needs the request bit set on two consecutive writes.
// RULE19 - A readable flag records whether the last reset was undervoltage, watchdog or pin.
// RULE20 - Without debounce the system stays in reset while the pin is low.
// RULE21 - Any system reset clears watchdog counter and prescaler.
package rpos_pkg;
	// Clock and timing.
	localparam int       CLK_PERIOD_NS = 50;
	localparam real      PWR_STAB_MS   = 4.6;
	localparam int       PWR_STAB_CYC  = int'($ceil(PWR_STAB_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam real      DEBOUNCE_MS   = 8.0;
	localparam int       DEBOUNCE_CYC  = int'($ceil(DEBOUNCE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int       CNT_W         = 18;
	localparam bit [11:0] OSC_STAB_CNT = 12'h800;
	localparam bit [2:0]  LSO_STAB_CNT = 3'h5;
	localparam bit [7:0]  WDT_LAST     = 8'hff;
	localparam bit [7:0]  WDT_KEY      = 8'h5a;
	localparam bit [15:0] RESET_VECTOR = 16'h0000;
	// Register byte addresses.
	localparam bit [7:0] CAUSE_ADDR = 8'h00;
	localparam bit [7:0] SOFT_ADDR  = 8'h04;
	localparam bit [7:0] WCLR_ADDR  = 8'h08;
	localparam bit [7:0] STAT_ADDR  = 8'h0c;
	// Field positions.
	localparam int CAUSE_UV_BIT  = 7;
	localparam int CAUSE_WDT_BIT = 6;
	localparam int CAUSE_PIN_BIT = 5;
	localparam int SOFT_REQ_BIT  = 0;
	localparam bit [1:0] RESP_OKAY   = 2'h0;
	localparam bit [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {CLK_INT32, CLK_INT32_RTC, CLK_XTAL_HI, CLK_XTAL_STD, CLK_EXT} rpos_clk_src_t;
	typedef enum logic [1:0] {WDT_ALWAYS, WDT_ENABLE, WDT_DISABLE} rpos_wdt_mode_t;
	typedef enum logic [1:0] {PIN_RST_DEB, PIN_RST_PLAIN, PIN_GPIO} rpos_pin_mode_t;
	typedef enum logic [2:0] {ST_HOLD, ST_PWR, ST_CLK, ST_RUN, ST_SOFT} rpos_state_t;

	typedef struct packed {
		rpos_clk_src_t  clk_src;
		rpos_wdt_mode_t wdt_mode;
		logic [1:0]     wdt_period;
		rpos_pin_mode_t pin_mode;
	} rpos_opts_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} rpos_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rpos_axi_rsp_t;
endpackage : rpos_pkg

// File: core/rpos_sequencer.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rpos_sequencer import rpos_pkg::*; #(
	parameter int PWR_CYC = PWR_STAB_CYC,
	parameter int DEB_CYC = DEBOUNCE_CYC
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire rpos_axi_req_t axi_req,
	output rpos_axi_rsp_t      axi_rsp,
	input  wire rpos_opts_t    opts,
	input  wire logic          undervoltage_detector,
	input  wire logic          shared_reset_gpio_in,
	input  wire logic          low_speed_osc,
	input  wire logic          selected_osc,
	input  wire logic          cpu_idle,
	input  wire logic          cpu_stop,
	output logic               sys_reset_n,
	output logic [15:0]        fetch_addr,
	output rpos_clk_src_t      clk_src_sel,
	output logic               osc_enable,
	output logic               osc_in_pin_gpio,
	output logic               osc_out_pin_gpio,
	output logic               shared_reset_gpio
);
	typedef struct packed {
		logic [2:0]       uv_s;
		logic [2:0]       pin_s;
		logic [2:0]       lso_s;
		logic [2:0]       osc_s;
		logic             uv_f;
		logic             pin_f;
		logic             lso_f;
		logic             osc_f;
		logic             lso_p;
		logic             osc_p;
		rpos_state_t      st;
		logic [CNT_W-1:0] seq_cnt;
		logic [CNT_W-1:0] deb_cnt;
		logic [11:0]      osc_cnt;
		logic [2:0]       lso_cnt;
		logic [4:0]       wdt_pre;
		logic [7:0]       wdt_cnt;
		logic             sys_rst_n;
		logic [15:0]      vec;
		rpos_clk_src_t    clk_src;
		logic             osc_en;
		logic             in_gpio;
		logic             out_gpio;
		logic             pin_gpio;
		logic [2:0]       cause;
		logic             soft_flag;
		logic             soft_armed;
		logic             aw_held;
		logic [7:0]       awaddr;
		logic             w_held;
		logic [7:0]       wbyte;
		logic             wstrb0;
		rpos_axi_rsp_t    rsp;
	} rpos_regs_t;

	rpos_regs_t q;
	rpos_regs_t d;
	logic       lso_rise;
	logic       osc_rise;
	logic       wdt_tick;
	logic       wdt_run;
	logic       wdt_exp;
	logic       key_wr;
	logic       pin_hold;
	logic       soft_trig;
	logic       do_write;

	// Takes a new level once the second and third stages agree.
	function automatic logic filt(input logic [2:0] s, input logic f);
		return (s[2] == s[1]) ? s[2] : f;
	endfunction : filt

	// Prescaler divide ratio minus one for the overflow-period option.
	function automatic logic [4:0] wdt_div_last(input logic [1:0] p);
		return 5'((5'h4 << p) - 5'h1);
	endfunction : wdt_div_last

	// Register read multiplexer.
	function automatic logic [31:0] reg_read(input rpos_regs_t r, input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		if (a == CAUSE_ADDR) begin
			v[CAUSE_UV_BIT]  = r.cause[2];
			v[CAUSE_WDT_BIT] = r.cause[1];
			v[CAUSE_PIN_BIT] = r.cause[0];
		end else if (a == SOFT_ADDR) begin
			v[SOFT_REQ_BIT] = r.soft_flag;
		end else if (a == STAT_ADDR) begin
			v[7:0]   = r.wdt_cnt;
			v[10:8]  = r.st;
			v[11]    = r.soft_armed;
		end
		return v;
	endfunction : reg_read

	function automatic logic addr_ok(input logic [7:0] a);
		return (a == CAUSE_ADDR) || (a == SOFT_ADDR) || (a == WCLR_ADDR) || (a == STAT_ADDR);
	endfunction : addr_ok

	// Event terms derived from the current state.
	always_comb begin
		lso_rise  = q.lso_f && !q.lso_p;
		osc_rise  = q.osc_f && !q.osc_p;
		do_write  = q.aw_held && q.w_held && !q.rsp.bvalid;
		key_wr    = do_write && (q.awaddr == WCLR_ADDR) && q.wstrb0 && (q.wbyte == WDT_KEY); // RULE9
		soft_trig = do_write && (q.awaddr == SOFT_ADDR) && q.wstrb0 && q.wbyte[SOFT_REQ_BIT]
			&& q.soft_armed; // RULE18
		wdt_run   = (q.st == ST_RUN) && ((opts.wdt_mode == WDT_ALWAYS) // RULE10
			|| ((opts.wdt_mode == WDT_ENABLE) && !cpu_idle && !cpu_stop)); // RULE11 RULE12
		wdt_tick  = wdt_run && lso_rise && (q.wdt_pre == wdt_div_last(opts.wdt_period)); // RULE13
		wdt_exp   = wdt_tick && (q.wdt_cnt == WDT_LAST); // RULE16 RULE8
		pin_hold  = !q.pin_f && ((opts.pin_mode == PIN_RST_PLAIN) // RULE20
			|| ((opts.pin_mode == PIN_RST_DEB) && (q.deb_cnt == CNT_W'(DEB_CYC - 1)))); // RULE17 RULE14
	end

	// Next-state logic for the whole block.
	always_comb begin
		d = q;
		// Pin synchronisers.
		d.uv_s  = {q.uv_s[1:0], undervoltage_detector};
		d.pin_s = {q.pin_s[1:0], shared_reset_gpio_in};
		d.lso_s = {q.lso_s[1:0], low_speed_osc};
		d.osc_s = {q.osc_s[1:0], selected_osc};
		d.uv_f  = filt(q.uv_s, q.uv_f);
		d.pin_f = filt(q.pin_s, q.pin_f);
		d.lso_f = filt(q.lso_s, q.lso_f);
		d.osc_f = filt(q.osc_s, q.osc_f);
		d.lso_p = q.lso_f;
		d.osc_p = q.osc_f;
		// Debounce timer runs only while the pin is low.
		if (q.pin_f || (opts.pin_mode != PIN_RST_DEB)) begin
			d.deb_cnt = '0; // RULE17
		end else if (q.deb_cnt != CNT_W'(DEB_CYC - 1)) begin
			d.deb_cnt = CNT_W'(q.deb_cnt + 1'b1);
		end
		// Watchdog prescaler and counter.
		if (!wdt_run) begin
			if (q.st != ST_RUN || opts.wdt_mode == WDT_DISABLE) begin
				d.wdt_pre = '0; // RULE21 RULE12
				d.wdt_cnt = '0;
			end
		end else if (lso_rise) begin
			d.wdt_pre = wdt_tick ? 5'h0 : 5'(q.wdt_pre + 1'b1); // RULE13
			if (wdt_tick) begin
				d.wdt_cnt = 8'(q.wdt_cnt + 1'b1);
			end
		end
		if (key_wr && !wdt_exp) begin
			d.wdt_pre = '0; // RULE9
			d.wdt_cnt = '0;
		end
		// Software reset arming: only back-to-back writes of the request bit count.
		if (do_write) begin
			d.soft_armed = (q.awaddr == SOFT_ADDR) && q.wstrb0 && q.wbyte[SOFT_REQ_BIT] && !q.soft_armed;
		end
		// Sequencer.
		case (q.st)
			ST_HOLD: begin
				d.osc_en = 1'b0;
				if (!q.uv_f && !pin_hold) begin
					d.st      = ST_PWR; // RULE3
					d.seq_cnt = '0;
				end
			end
			ST_PWR: begin
				d.seq_cnt = CNT_W'(q.seq_cnt + 1'b1);
				if (q.seq_cnt == CNT_W'(PWR_CYC - 1)) begin
					d.st      = ST_CLK; // RULE4
					d.clk_src = opts.clk_src; // RULE5
					d.osc_en  = 1'b1;
					d.osc_cnt = '0;
					d.lso_cnt = '0;
				end
			end
			ST_CLK: begin
				if (osc_rise && q.osc_cnt != OSC_STAB_CNT) begin
					d.osc_cnt = 12'(q.osc_cnt + 1'b1); // RULE6
				end
				if (lso_rise && q.lso_cnt != LSO_STAB_CNT) begin
					d.lso_cnt = 3'(q.lso_cnt + 1'b1);
				end
				if (q.osc_cnt == OSC_STAB_CNT && q.lso_cnt == LSO_STAB_CNT) begin
					d.st = ST_RUN; // RULE6
				end
			end
			ST_SOFT: begin
				d.st = ST_RUN;
			end
			default: begin
				if (soft_trig) begin
					d.st         = ST_SOFT; // RULE1
					d.cause      = '0;
					d.soft_flag  = 1'b1;
					d.soft_armed = 1'b0;
				end
			end
		endcase
		// Hardware sources restart the full sequence and record their cause.
		if (q.uv_f || pin_hold || wdt_exp) begin
			d.st = ST_HOLD; // RULE1
			if (q.st == ST_RUN || q.st == ST_SOFT) begin
				d.cause     = '0;
				d.soft_flag = 1'b0;
			end
			d.cause      = d.cause | {q.uv_f, wdt_exp, pin_hold}; // RULE19 RULE7
			d.soft_armed = 1'b0;
		end
		d.sys_rst_n = (d.st == ST_RUN); // RULE2
		d.vec       = RESET_VECTOR; // RULE2
		d.in_gpio   = (d.clk_src == CLK_INT32); // RULE15
		d.out_gpio  = (d.clk_src == CLK_INT32) || (d.clk_src == CLK_EXT);
		d.pin_gpio  = (opts.pin_mode == PIN_GPIO); // RULE14
		// AXI4-Lite write channels, taken in either order.
		if (q.rsp.awready && axi_req.awvalid) begin
			d.aw_held     = 1'b1;
			d.awaddr      = axi_req.awaddr;
			d.rsp.awready = 1'b0;
		end
		if (q.rsp.wready && axi_req.wvalid) begin
			d.w_held     = 1'b1;
			d.wbyte      = axi_req.wdata[7:0];
			d.wstrb0     = axi_req.wstrb[0];
			d.rsp.wready = 1'b0;
		end
		if (do_write) begin
			d.aw_held    = 1'b0;
			d.w_held     = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp  = addr_ok(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid  = 1'b0;
			d.rsp.awready = 1'b1;
			d.rsp.wready  = 1'b1;
		end
		// AXI4-Lite read channel.
		if (q.rsp.arready && axi_req.arvalid) begin
			d.rsp.arready = 1'b0;
			d.rsp.rvalid  = 1'b1;
			d.rsp.rdata   = reg_read(q, axi_req.araddr);
			d.rsp.rresp   = addr_ok(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid  = 1'b0;
			d.rsp.arready = 1'b1;
		end
	end

	// State register; reset sets the bus ready flags, so the bus is open as soon as reset is released.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q             <= '0;
			q.pin_s       <= 3'h7;
			q.pin_f       <= 1'b1;
			q.in_gpio     <= 1'b1;
			q.out_gpio    <= 1'b1;
			q.rsp.awready <= 1'b1;
			q.rsp.wready  <= 1'b1;
			q.rsp.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register.
	assign axi_rsp           = q.rsp;
	assign sys_reset_n       = q.sys_rst_n;
	assign fetch_addr        = q.vec;
	assign clk_src_sel       = q.clk_src;
	assign osc_enable        = q.osc_en;
	assign osc_in_pin_gpio   = q.in_gpio;
	assign osc_out_pin_gpio  = q.out_gpio;
	assign shared_reset_gpio = q.pin_gpio;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// While the CPU is held in reset, the fetch address stays at the reset vector.
	vector_hold_a: assert property (!q.sys_rst_n |-> q.vec == RESET_VECTOR) // RULE2
		else $error("fetch address not at reset vector");
	power_to_clock_a: assert property ((q.st == ST_PWR && q.seq_cnt == CNT_W'(PWR_CYC - 1)
		&& !q.uv_f && !pin_hold && !wdt_exp) |=> (q.st == ST_CLK && q.osc_en && q.clk_src == $past(opts.clk_src))) // RULE5
		else $error("clock source not loaded at end of power stage");
	power_len_a: assert property ($rose(q.st == ST_CLK) |-> $past(q.seq_cnt) == CNT_W'(PWR_CYC - 1)) // RULE4
		else $error("power stage ended early");
	clock_done_a: assert property ((q.st == ST_CLK) ##1 (q.st == ST_RUN)
		|-> $past(q.osc_cnt) == OSC_STAB_CNT && $past(q.lso_cnt) == LSO_STAB_CNT) // RULE6
		else $error("clock stage ended before both counts");
	undervolt_rst_a: assert property (q.uv_f |=> !q.sys_rst_n && q.cause[2]) // RULE7
		else $error("undervoltage did not reset");
	wdt_key_a: assert property (key_wr && !wdt_exp |=> q.wdt_cnt == 8'h00 && q.wdt_pre == 5'h0) // RULE9
		else $error("watchdog key did not restart count");
	wdt_halt_a: assert property ((opts.wdt_mode == WDT_ENABLE && (cpu_idle || cpu_stop) && !key_wr
		&& q.st == ST_RUN) |=> $stable(q.wdt_cnt)) // RULE11
		else $error("enabled watchdog counted in low power");
	wdt_always_a: assert property ((opts.wdt_mode == WDT_ALWAYS && wdt_tick && !key_wr && !wdt_exp)
		|=> q.wdt_cnt == 8'($past(q.wdt_cnt) + 1'b1)) // RULE10
		else $error("always-on watchdog missed a tick");
	wdt_off_a: assert property (opts.wdt_mode == WDT_DISABLE |-> !wdt_exp ##1 q.wdt_cnt == 8'h00) // RULE12
		else $error("disabled watchdog active");
	wdt_expire_a: assert property (wdt_exp |=> q.st == ST_HOLD && q.cause[1] && !q.sys_rst_n) // RULE16
		else $error("watchdog expiry did not reset");
	pin_plain_a: assert property (opts.pin_mode == PIN_RST_PLAIN && !q.pin_f |=> !q.sys_rst_n) // RULE20
		else $error("plain reset pin low without reset");
	pin_short_a: assert property (opts.pin_mode == PIN_RST_DEB && q.pin_f |=> q.deb_cnt == '0) // RULE17
		else $error("debounce timer not restarted");
	soft_reset_a: assert property (soft_trig && !q.uv_f && !pin_hold && !wdt_exp
		|=> q.st == ST_SOFT && !q.sys_rst_n ##1 q.st == ST_RUN) // RULE18
		else $error("soft reset sequence wrong");
	wdt_clear_a: assert property (q.st != ST_RUN |=> q.wdt_cnt == 8'h00 || q.st == ST_RUN) // RULE21
		else $error("watchdog not cleared by reset");

	run_reached_c: cover property ((q.st == ST_CLK) ##1 (q.st == ST_RUN));
	wdt_fire_c: cover property (wdt_exp);
	soft_fire_c: cover property (soft_trig);
	debounce_fire_c: cover property (opts.pin_mode == PIN_RST_DEB && pin_hold);
endmodule : rpos_sequencer
`default_nettype wire

// File: test/rpos_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module rpos_osc_model (
	input  wire logic   aclk,
	input  wire logic   osc_enable,
	input  wire logic   sys_reset_n,
	output logic        low_speed_osc,
	output logic        selected_osc,
	output logic [31:0] off_cyc,
	output logic [31:0] sel_rises
);
	logic [1:0] div_q;
	logic       rst_q;
	logic       sel_ph;

	// Both oscillators start low and the counts start empty.
	initial begin
		div_q = 2'h0;
		rst_q = 1'b1;
		sel_ph = 1'b0;
		low_speed_osc = 1'b0;
		selected_osc = 1'b0;
		off_cyc = 32'h0;
		sel_rises = 32'h0;
	end

	// The slow oscillator runs free; the fast one stands still unless driven.
	// The fast one toggles every second cycle, since the three-stage input filter needs each level twice.
	// While reset is held it tallies cycles without the fast clock and fast rises.
	always @(posedge aclk) begin
		div_q <= div_q + 2'h1;
		rst_q <= sys_reset_n;
		if (div_q == 2'h3) low_speed_osc <= ~low_speed_osc;
		if (osc_enable === 1'b1) sel_ph <= ~sel_ph;
		if (osc_enable === 1'b1 && sel_ph) selected_osc <= ~selected_osc;
		if (rst_q === 1'b1 && sys_reset_n !== 1'b1) begin
			off_cyc <= 32'h0;
			sel_rises <= 32'h0;
		end else if (sys_reset_n !== 1'b1) begin
			if (osc_enable !== 1'b1) off_cyc <= off_cyc + 32'h1;
			if (osc_enable === 1'b1 && sel_ph && !selected_osc) sel_rises <= sel_rises + 32'h1;
		end
	end
endmodule : rpos_osc_model
`default_nettype wire

// File: test/test_reset_power_on_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_reset_power_on_sequencer import rpos_pkg::*; ;
	localparam int PWR = 20;
	localparam int DEB = 10;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	rpos_axi_req_t req = '0;
	rpos_axi_rsp_t rsp;
	rpos_opts_t    opts = '0;
	rpos_clk_src_t csel;
	logic          uv, pin, idle, stop, sys_n, oen, gin, gout, pgpio, lso, sel, prev_q = 1'b1;
	logic [15:0]   fa;
	logic [31:0]   off_cyc, sel_rises, d, c1, v;
	int            error_cnt = 0, checked = 0, cyc = 0, falls = 0, lo_run = 0, last_lo = 0, k, n, f0;
	integer        seed = 32'hbb8966e4;

	always #25 aclk = ~aclk;

	rpos_sequencer #(.PWR_CYC(PWR), .DEB_CYC(DEB)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(rsp), .opts(opts), .undervoltage_detector(uv), .shared_reset_gpio_in(pin),
		.low_speed_osc(lso), .selected_osc(sel), .cpu_idle(idle), .cpu_stop(stop), .sys_reset_n(sys_n),
		.fetch_addr(fa), .clk_src_sel(csel), .osc_enable(oen), .osc_in_pin_gpio(gin),
		.osc_out_pin_gpio(gout), .shared_reset_gpio(pgpio));

	rpos_osc_model osc (.aclk(aclk), .osc_enable(oen), .sys_reset_n(sys_n), .low_speed_osc(lso),
		.selected_osc(sel), .off_cyc(off_cyc), .sel_rises(sel_rises));

	// Counts reset assertions, keeps the length of the last one, and cuts a hang short.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		prev_q <= sys_n;
		if (prev_q === 1'b1 && sys_n === 1'b0) falls <= falls + 1;
		if (sys_n === 1'b0) lo_run <= lo_run + 1;
		else if (lo_run != 0) begin
			last_lo <= lo_run;
			lo_run <= 0;
		end
		if (cyc == 96000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task report_and_stop();
		if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	function automatic logic [1:0] gpio_exp(input rpos_clk_src_t s);
		return {s == CLK_INT32, s == CLK_INT32 || s == CLK_EXT};
	endfunction : gpio_exp

	task wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
		int t;
		t = 0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= x;
		do begin
			@(posedge aclk);
			t++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && t < 50);
		`CHK({t < 50, rsp.bresp}, {1'b1, er}, "write response")
	endtask : wr

	task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] x);
		int t;
		t = 0;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		do begin
			@(posedge aclk);
			t++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && t < 50);
		x = rsp.rdata;
		`CHK({t < 50, rsp.rresp}, {1'b1, er}, "read response")
	endtask : rd

	task wait_fall(input int lim, output int t);
		int f;
		f = falls;
		t = 0;
		while (falls == f && t < lim) begin
			@(posedge aclk);
			t++;
		end
	endtask : wait_fall

	// Waits for release and checks what the power-on sequence left behind.
	task till_run();
		int t;
		t = 0;
		while (sys_n !== 1'b1 && t < 9000) begin
			@(posedge aclk);
			t++;
		end
		`CHK(t < 9000, 1'b1, "no release")
		`CHK(off_cyc >= PWR, 1'b1, "power stage short")
		`CHK(sel_rises >= 2048 && sel_rises <= 2052, 1'b1, "clock stage count")
		`CHK(csel, opts.clk_src, "clock source")
		`CHK(oen, 1'b1, "oscillator off")
		`CHK(fa, RESET_VECTOR, "vector")
		`CHK({gin, gout}, gpio_exp(opts.clk_src), "oscillator pins")
		`CHK(pgpio, opts.pin_mode == PIN_GPIO, "pin use")
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[10:8], 3'h3, "state")
		`CHK(d[7:0] < 8'h2, 1'b1, "watchdog count")
	endtask : till_run

	task boot(input rpos_opts_t o);
		aresetn <= 1'b0;
		opts <= o;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		till_run();
	endtask : boot

	// Main sequence: one boot per option set, with faults injected after each boot.
	initial begin
		uv = 1'b0;
		pin = 1'b1;
		idle = 1'b0;
		stop = 1'b0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		req.wstrb = 4'hf;
		k = $unsigned($random(seed)) % 5;
		boot('{rpos_clk_src_t'(k[2:0]), WDT_ALWAYS, 2'h0, PIN_RST_DEB});
		rd(CAUSE_ADDR, RESP_OKAY, d);
		`CHK(d, 32'h0, "cause after power-on")
		rd(8'h10, RESP_SLVERR, d);
		wr(8'h14, 32'h1, RESP_SLVERR);
		f0 = falls;
		repeat (6) begin
			k = 600 + $unsigned($random(seed)) % 1000;
			repeat (k) @(posedge aclk);
			wr(WCLR_ADDR, ($random(seed) & 32'hffffff00) | 32'h5a, RESP_OKAY);
		end
		`CHK(falls, f0, "watchdog fired despite clears")
		repeat (900) @(posedge aclk);
		rd(STAT_ADDR, RESP_OKAY, c1);
		v = $random(seed);
		if (v[7:0] == WDT_KEY) v[7:0] = 8'h5b;
		wr(WCLR_ADDR, v, RESP_OKAY);
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[7:0] >= c1[7:0], 1'b1, "wrong key cleared")
		wr(WCLR_ADDR, 32'h5a, RESP_OKAY);
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[7:0] < 8'h2, 1'b1, "key did not clear")
		stop <= 1'b1;
		rd(STAT_ADDR, RESP_OKAY, c1);
		repeat (300) @(posedge aclk);
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[7:0] > c1[7:0], 1'b1, "halted in stop")
		stop <= 1'b0;
		wr(WCLR_ADDR, 32'h5a, RESP_OKAY);
		wait_fall(9000, n);
		`CHK(n >= 8170 && n <= 8215, 1'b1, "expiry time")
		till_run();
		rd(CAUSE_ADDR, RESP_OKAY, d);
		`CHK(d, 32'h40, "watchdog cause")
		f0 = falls;
		wr(SOFT_ADDR, 32'h1, RESP_OKAY);
		wr(SOFT_ADDR, 32'h0, RESP_OKAY);
		wr(SOFT_ADDR, 32'h1, RESP_OKAY);
		repeat (10) @(posedge aclk);
		`CHK(falls, f0, "broken pair reset")
		wr(SOFT_ADDR, 32'h1, RESP_OKAY);
		repeat (10) @(posedge aclk);
		`CHK({falls, last_lo}, {f0 + 1, 32'd1}, "soft pulse")
		`CHK(off_cyc, 32'h0, "soft ran power-on")
		rd(SOFT_ADDR, RESP_OKAY, d);
		`CHK(d, 32'h1, "soft flag")
		pin <= 1'b0;
		repeat (DEB - 4) @(posedge aclk);
		pin <= 1'b1;
		wait_fall(30, n);
		`CHK(n, 30, "short pulse reset")
		pin <= 1'b0;
		wait_fall(DEB + 20, n);
		`CHK(n >= DEB && n < DEB + 20, 1'b1, "debounce time")
		repeat (10) @(posedge aclk);
		`CHK(sys_n, 1'b0, "pin hold")
		pin <= 1'b1;
		@(posedge aclk);
		till_run();
		rd(CAUSE_ADDR, RESP_OKAY, d);
		`CHK(d, 32'h20, "pin cause")
		boot('{CLK_XTAL_HI, WDT_ENABLE, 2'h0, PIN_RST_PLAIN});
		idle <= 1'b1;
		rd(STAT_ADDR, RESP_OKAY, c1);
		repeat (300) @(posedge aclk);
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[7:0], c1[7:0], "counted in idle")
		idle <= 1'b0;
		pin <= 1'b0;
		repeat (DEB - 3) @(posedge aclk);
		`CHK(sys_n, 1'b0, "plain pin late")
		repeat (20) @(posedge aclk);
		`CHK(sys_n, 1'b0, "plain pin hold")
		pin <= 1'b1;
		@(posedge aclk);
		till_run();
		uv <= 1'b1;
		repeat (30) @(posedge aclk);
		`CHK(sys_n, 1'b0, "undervoltage")
		uv <= 1'b0;
		@(posedge aclk);
		till_run();
		rd(CAUSE_ADDR, RESP_OKAY, d);
		`CHK(d, 32'h80, "undervoltage cause")
		boot('{CLK_INT32, WDT_DISABLE, 2'($random(seed)), PIN_GPIO});
		f0 = falls;
		pin <= 1'b0;
		repeat (9000) @(posedge aclk);
		pin <= 1'b1;
		rd(STAT_ADDR, RESP_OKAY, d);
		`CHK(d[7:0], 8'h0, "disabled counted")
		`CHK(falls, f0, "disabled or gpio reset")
		report_and_stop();
	end
endmodule : test_reset_power_on_sequencer
`default_nettype wire
